// [hw/half_bit_ticker.sv]
// Half-bit enable divider for the serial clock
`timescale 1ns/100ps

module half_bit_ticker #(
  parameter int unsigned DIV = 500
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset
  input wire logic run, // Count while high
  output logic tick // One-cycle enable
);

  logic [15:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      // Restart so every phase gets a full half bit
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : half_bit_ticker

// [hw/two_wire_defines.svh]
// Offsets, fields, status codes, timing
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

// ==========================================================================
// Register offsets
`define OFF_CONTROL 3'h0
`define OFF_STATUS 3'h1
`define OFF_DATA 3'h2
`define OFF_EVT_STATUS 3'h3
`define OFF_EVT_MASK 3'h4

// ==========================================================================
// Control fields
`define CTL_IRQ_FLAG 7
`define CTL_ACK_ENABLE 6
`define CTL_START_REQUEST 5
`define CTL_STOP_REQUEST 4
`define CTL_WRITE_COLLISION 3
`define CTL_IFACE_ENABLE 2
`define CTL_IRQ_ENABLE 0

// ==========================================================================
// Event bits
`define EVT_FLAG_SET 0
`define EVT_ARB_LOST 1
`define EVT_STOP_SENT 2
`define EVT_WIDTH 3

// ==========================================================================
// Status codes, prescaler bits zero
`define ST_START_SENT 8'h08
`define ST_RSTART_SENT 8'h10
`define ST_MT_ADDR_ACK 8'h18
`define ST_MT_ADDR_NACK 8'h20
`define ST_ARB_LOST 8'h38
`define ST_MR_ADDR_ACK 8'h40
`define ST_MR_ADDR_NACK 8'h48
`define ST_MR_DATA_ACK 8'h50
`define ST_MR_DATA_NACK 8'h58
`define ST_IDLE_CODE 8'hF8

// ==========================================================================
// Timing
`define CLK_HZ 100000000
`define SCL_HZ 100000
`define HALF_BIT_CYCLES (`CLK_HZ / (2 * `SCL_HZ))

`endif

// [hw/two_wire_master_receiver.sv]
// Two-wire master receiver with register port and interrupt
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "two_wire_defines.svh"

// Overview of operation
// - Read address enters receiver mode, write address enters transmitter mode.
// - Status codes are given with prescaler bits reading zero.
// - Enable, start and flag written one: wait for free bus, send START.
// - After START, set flag and report 0x08.
// - After address and acknowledge, set flag, report 0x38, 0x40 or 0x48.
// - Received byte sits in data register whenever flag is set after it.
// - Flag one, stop set, start clear, enable set: transmit STOP.
// - Flag one with start while holding bus: repeated START, report 0x10.
// - In 0x10 read address stays receiver, write address switches transmitter.
// - On 0x38 clear releases bus, or with start waits free then START.
// - In 0x40 clearing flag receives byte, acknowledging per ack enable.
// - In 0x48 clearing flag gives repeated START, STOP, or STOP then START.
// - 0x50 means byte acknowledged; next byte acknowledged per ack enable.
// - 0x58 means byte not acknowledged; then repeated START, STOP or both.
// - Hardware clears stop request once the STOP has been sent.
// - Start and stop both set: STOP immediately followed by new START.
module two_wire_master_receiver #(
  parameter int unsigned HALF_BIT = `HALF_BIT_CYCLES
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset
  input two_wire_pkg::reg_req_type req, // Register port request
  output logic [7:0] rdata, // Read data, cycle after read strobe
  output logic irq, // Level interrupt
  input wire logic scl_i, // Serial clock line level
  output logic scl_oe, // Pull serial clock low
  input wire logic sda_i, // Serial data line level
  output logic sda_oe // Pull serial data low
);

  import two_wire_pkg::*;

  // ========================================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_s;
  logic sda_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];

  // ========================================================================
  // Register port decode
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  logic ctrl_wr;
  logic go;
  logic data_wr;
  logic evt_wr;
  logic mask_wr;

  assign ctrl_wr = req.wr && hit(req.addr, `OFF_CONTROL);
  assign data_wr = req.wr && hit(req.addr, `OFF_DATA);
  assign evt_wr = req.wr && hit(req.addr, `OFF_EVT_STATUS);
  assign mask_wr = req.wr && hit(req.addr, `OFF_EVT_MASK);
  assign go = ctrl_wr && req.wdata[`CTL_IRQ_FLAG] &&
              req.wdata[`CTL_IFACE_ENABLE];

  // ========================================================================
  // Sequencer state
  seq_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] code_reg;
  logic rx_phase_reg;
  logic nack_bit_reg;
  logic is_read_reg;
  logic restart_reg;
  logic then_start_reg;
  logic master_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic flag_set_reg;
  logic rx_valid_reg;
  logic stop_done_reg;
  logic arb_lost_reg;
  logic bus_busy_reg;
  logic tick;
  logic tick_run;

  logic flag_reg;
  logic ack_en_reg;
  logic sta_reg;
  logic sto_reg;
  logic wcol_reg;
  logic en_reg;
  logic ie_reg;
  logic [7:0] data_reg;
  logic [`EVT_WIDTH-1:0] evt_reg;
  logic [`EVT_WIDTH-1:0] mask_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;

  assign tick_run = (state_reg != S_IDLE) && (state_reg != S_HOLD) &&
                    (state_reg != S_LOST);

  half_bit_ticker #(
    .DIV(HALF_BIT)
  ) u_ticker (
    .clk(clk),
    .rst_n(rst_n),
    .run(tick_run),
    .tick(tick)
  );

  // ========================================================================
  // Bus busy from START and STOP on the lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_reg <= 1'b0;
    end else if (scl_s && scl_prev_reg && sda_prev_reg && !sda_s) begin
      bus_busy_reg <= 1'b1;
    end else if (scl_s && scl_prev_reg && !sda_prev_reg && sda_s) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Bus sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      code_reg <= `ST_IDLE_CODE;
      rx_phase_reg <= 1'b0;
      nack_bit_reg <= 1'b0;
      is_read_reg <= 1'b0;
      restart_reg <= 1'b0;
      then_start_reg <= 1'b0;
      master_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      flag_set_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      stop_done_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
    end else begin
      flag_set_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      stop_done_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
          restart_reg <= 1'b0;
          if (go && req.wdata[`CTL_START_REQUEST]) begin
            state_reg <= S_WAIT_FREE;
          end else if (go && req.wdata[`CTL_STOP_REQUEST]) begin
            stop_done_reg <= 1'b1; // Not master: nothing to send
          end
        end
        S_WAIT_FREE: begin
          if (tick && !bus_busy_reg && scl_s && sda_s) begin
            sda_oe_reg <= 1'b1;
            state_reg <= S_START_A;
          end
        end
        S_START_A: begin
          if (tick) begin
            scl_oe_reg <= 1'b1;
            state_reg <= S_START_B;
          end
        end
        S_START_B: begin
          if (tick) begin
            master_reg <= 1'b1;
            code_reg <= restart_reg ? `ST_RSTART_SENT : `ST_START_SENT;
            flag_set_reg <= 1'b1;
            state_reg <= S_HOLD;
          end
        end
        S_HOLD: begin
          scl_oe_reg <= 1'b1;
          if (go && flag_reg) begin
            bit_cnt_reg <= 4'h0;
            if (code_reg == `ST_START_SENT || code_reg == `ST_RSTART_SENT) begin
              shift_reg <= data_reg;
              is_read_reg <= data_reg[0];
              rx_phase_reg <= 1'b0;
              state_reg <= S_BIT_LOW;
            end else if (code_reg == `ST_MR_ADDR_ACK ||
                         code_reg == `ST_MR_DATA_ACK) begin
              rx_phase_reg <= 1'b1;
              nack_bit_reg <= !req.wdata[`CTL_ACK_ENABLE];
              state_reg <= S_BIT_LOW;
            end else if (req.wdata[`CTL_STOP_REQUEST]) begin
              then_start_reg <= req.wdata[`CTL_START_REQUEST];
              state_reg <= S_STOP_A;
            end else if (req.wdata[`CTL_START_REQUEST]) begin
              state_reg <= S_RSTART_A;
            end
          end
        end
        S_LOST: begin
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
          if (go && flag_reg) begin
            restart_reg <= 1'b0;
            if (req.wdata[`CTL_START_REQUEST]) begin
              state_reg <= S_WAIT_FREE;
            end else begin
              code_reg <= `ST_IDLE_CODE;
              state_reg <= S_IDLE;
            end
          end
        end
        S_BIT_LOW: begin
          scl_oe_reg <= 1'b1;
          if (bit_cnt_reg < 4'h8) begin
            sda_oe_reg <= rx_phase_reg ? 1'b0 : !shift_reg[7];
          end else begin
            sda_oe_reg <= rx_phase_reg ? !nack_bit_reg : 1'b0;
          end
          if (tick) begin
            scl_oe_reg <= 1'b0;
            state_reg <= S_BIT_HIGH;
          end
        end
        S_BIT_HIGH: begin
          // Clock stretching: wait for line high
          if (tick && scl_s) begin
            if (!sda_oe_reg && !sda_s &&
                ((!rx_phase_reg && bit_cnt_reg < 4'h8) ||
                 (rx_phase_reg && bit_cnt_reg == 4'h8))) begin
              code_reg <= `ST_ARB_LOST;
              master_reg <= 1'b0;
              arb_lost_reg <= 1'b1;
              flag_set_reg <= 1'b1;
              sda_oe_reg <= 1'b0;
              state_reg <= S_LOST;
            end else if (bit_cnt_reg < 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              scl_oe_reg <= 1'b1;
              state_reg <= S_BIT_LOW;
            end else begin
              scl_oe_reg <= 1'b1;
              sda_oe_reg <= 1'b0;
              flag_set_reg <= 1'b1;
              state_reg <= S_HOLD;
              if (rx_phase_reg) begin
                rx_valid_reg <= 1'b1;
                code_reg <= nack_bit_reg ? `ST_MR_DATA_NACK
                                         : `ST_MR_DATA_ACK;
              end else if (is_read_reg) begin
                code_reg <= sda_s ? `ST_MR_ADDR_NACK
                                  : `ST_MR_ADDR_ACK;
              end else begin
                code_reg <= sda_s ? `ST_MT_ADDR_NACK
                                  : `ST_MT_ADDR_ACK;
              end
            end
          end
        end
        S_STOP_A: begin
          scl_oe_reg <= 1'b1;
          sda_oe_reg <= 1'b1;
          if (tick) begin
            scl_oe_reg <= 1'b0;
            state_reg <= S_STOP_B;
          end
        end
        S_STOP_B: begin
          if (tick && scl_s) begin
            sda_oe_reg <= 1'b0;
            state_reg <= S_STOP_C;
          end
        end
        S_STOP_C: begin
          if (tick) begin
            stop_done_reg <= 1'b1;
            master_reg <= 1'b0;
            restart_reg <= 1'b0;
            code_reg <= `ST_IDLE_CODE;
            state_reg <= then_start_reg ? S_WAIT_FREE : S_IDLE;
          end
        end
        S_RSTART_A: begin
          scl_oe_reg <= 1'b1;
          sda_oe_reg <= 1'b0;
          if (tick) begin
            scl_oe_reg <= 1'b0;
            state_reg <= S_RSTART_B;
          end
        end
        S_RSTART_B: begin
          if (tick && scl_s && sda_s) begin
            sda_oe_reg <= 1'b1;
            restart_reg <= 1'b1;
            state_reg <= S_START_A;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Control; hardware flag set beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (flag_set_reg) begin
      flag_reg <= 1'b1;
    end else if (ctrl_wr && req.wdata[`CTL_IRQ_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_en_reg <= 1'b0;
      sta_reg <= 1'b0;
      en_reg <= 1'b0;
      ie_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ack_en_reg <= req.wdata[`CTL_ACK_ENABLE];
      sta_reg <= req.wdata[`CTL_START_REQUEST];
      en_reg <= req.wdata[`CTL_IFACE_ENABLE];
      ie_reg <= req.wdata[`CTL_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sto_reg <= 1'b0;
    end else if (ctrl_wr) begin
      sto_reg <= req.wdata[`CTL_STOP_REQUEST];
    end else if (stop_done_reg) begin
      sto_reg <= 1'b0;
    end
  end

  // Data writes refused while a byte moves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcol_reg <= 1'b0;
    end else if (data_wr) begin
      wcol_reg <= !flag_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 8'hFF;
    end else if (rx_valid_reg) begin
      data_reg <= shift_reg;
    end else if (data_wr && flag_reg) begin
      data_reg <= req.wdata;
    end
  end

  // ========================================================================
  // Event status, mask and interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= (evt_reg & ~(evt_wr ? req.wdata[`EVT_WIDTH-1:0]
                                     : {`EVT_WIDTH{1'b0}})) |
                 {stop_done_reg, arb_lost_reg, flag_set_reg};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= req.wdata[`EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_reg & mask_reg);
    end
  end

  // ========================================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (req.rd) begin
      if (hit(req.addr, `OFF_CONTROL)) begin
        rdata_reg <= {flag_reg, ack_en_reg, sta_reg, sto_reg, wcol_reg,
                      en_reg, 1'b0, ie_reg};
      end else if (hit(req.addr, `OFF_STATUS)) begin
        rdata_reg <= {code_reg[7:3], 3'h0};
      end else if (hit(req.addr, `OFF_DATA)) begin
        rdata_reg <= data_reg;
      end else if (hit(req.addr, `OFF_EVT_STATUS)) begin
        rdata_reg <= {5'h00, evt_reg};
      end else if (hit(req.addr, `OFF_EVT_MASK)) begin
        rdata_reg <= {5'h00, mask_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;

endmodule : two_wire_master_receiver

// [hw/two_wire_pkg.sv]
// Types of the two-wire master receiver
package two_wire_pkg;

  // ========================================================================
  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // ========================================================================
  // Bus sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_WAIT_FREE,
    S_START_A,
    S_START_B,
    S_HOLD,
    S_LOST,
    S_BIT_LOW,
    S_BIT_HIGH,
    S_STOP_A,
    S_STOP_B,
    S_STOP_C,
    S_RSTART_A,
    S_RSTART_B
  } seq_state_type;

endpackage : two_wire_pkg

// [testbench/slave_transmitter_model.sv]
// Slave transmitter on the far side of the two-wire bus
`timescale 1ns/100ps

module slave_transmitter_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic clk, // Sampling clock
  input wire logic scl, // Clock line level
  input wire logic sda, // Data line level
  input wire logic [7:0] seed, // First byte sent
  input wire logic [3:0] stretch, // Stretch per bit, cycles
  output logic scl_oe, // Pull clock low
  output logic sda_oe, // Pull data low
  output logic [7:0] stops // STOP conditions seen
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic addr_ph = 1'b0;
  logic send = 1'b0;
  logic acked = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [7:0] shift = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] nxt;
  initial sda_oe = 1'b0;
  initial stops = 8'h00;
  assign scl_oe = hold != 4'h0;
  assign nxt = tx + 8'h01;
  // ====
  // Released lines float to the pull-ups
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold != 4'h0) hold <= hold - 4'h1;
    if (scl && scl_q && sda_q && !sda) begin
      addr_ph <= 1'b1;
      send <= 1'b0;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      addr_ph <= 1'b0;
      send <= 1'b0;
      sda_oe <= 1'b0;
      stops <= stops + 8'h01;
    end else if (scl && !scl_q) begin
      cnt <= cnt + 4'h1;
      if (cnt < 4'h8) shift <= {shift[6:0], sda};
      else acked <= !sda;
    end else if (!scl && scl_q && (addr_ph || send)) begin
      hold <= stretch;
      if (cnt == 4'h8 && addr_ph) sda_oe <= shift == {ADDR, 1'b1};
      else if (cnt == 4'h8) sda_oe <= 1'b0;
      else if (cnt == 4'h9 && addr_ph) begin
        cnt <= 4'h0;
        addr_ph <= 1'b0;
        send <= sda_oe;
        tx <= seed;
        sda_oe <= sda_oe && !seed[7];
      end else if (cnt == 4'h9) begin
        // A refused byte ends the burst
        cnt <= 4'h0;
        send <= acked;
        tx <= nxt;
        sda_oe <= acked && !nxt[7];
      end else if (send) sda_oe <= !tx[3'd7 - cnt[2:0]];
    end
  end
endmodule : slave_transmitter_model

// [testbench/testbench.sv]
// Bench for the two-wire master receiver
`timescale 1ns/100ps
`include "two_wire_defines.svh"

module testbench;
  import two_wire_pkg::*;
  localparam int unsigned HB = 4;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [7:0] SEED = 8'hC3;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_type req = '0;
  logic [7:0] rdata;
  logic [7:0] stops;
  logic irq, scl_oe, sda_oe, slv_scl_oe, slv_sda_oe;
  logic rival = 1'b0;
  logic [3:0] stretch = 4'h0;
  int errors = 0;
  int total_checks = 0;
  wire scl_line = !(scl_oe || slv_scl_oe);
  wire sda_line = !(sda_oe || slv_sda_oe || rival);

  two_wire_master_receiver #(.HALF_BIT(HB)) two_wire_master_receiver_i (
    .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .irq(irq),
    .scl_i(scl_line), .scl_oe(scl_oe), .sda_i(sda_line), .sda_oe(sda_oe));
  slave_transmitter_model #(.ADDR(ADDR)) slave_transmitter_model_i (
    .clk(clk), .scl(scl_line), .sda(sda_line), .seed(SEED),
    .stretch(stretch), .scl_oe(slv_scl_oe), .sda_oe(slv_sda_oe),
    .stops(stops));

  // ====
  // Register port and comparison helpers
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  task automatic check8(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic expect_reg(input string what, input logic [2:0] a,
                            input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check8(what, exp, d);
  endtask : expect_reg
  // Bounded control poll
  task automatic poll(input string what, input logic [7:0] m, v);
    logic [7:0] d;
    int n;
    d = ~v;
    n = 0;
    while ((d & m) !== v && n < 400) begin
      rd(`OFF_CONTROL, d);
      n++;
    end
    check8(what, v, d & m);
  endtask : poll
  task automatic step(input logic [7:0] ctl, code);
    wr(`OFF_CONTROL, ctl);
    poll("irq flag", 8'h80, 8'h80);
    expect_reg("status", `OFF_STATUS, code);
  endtask : step
  task automatic stop_seq;
    logic [7:0] s;
    s = stops;
    wr(`OFF_CONTROL, 8'h95);
    poll("stop request", 8'h10, 8'h00);
    repeat (4 * HB) @(posedge clk);
    check8("stops seen", s + 8'h01, stops);
    check8("lines idle", 8'h03, {6'h00, scl_line, sda_line});
  endtask : stop_seq

  // ====
  // Scenarios
  task automatic test_regs;
    expect_reg("control reset", `OFF_CONTROL, 8'h00);
    expect_reg("status reset", `OFF_STATUS, 8'hF8);
    expect_reg("data reset", `OFF_DATA, 8'hFF);
    expect_reg("events reset", `OFF_EVT_STATUS, 8'h00);
    expect_reg("mask reset", `OFF_EVT_MASK, 8'h00);
    wr(3'h5, 8'hFF);
    expect_reg("unmapped", 3'h5, 8'h00);
    wr(`OFF_DATA, 8'h5A);
    expect_reg("collision", `OFF_CONTROL, 8'h08);
    expect_reg("data kept", `OFF_DATA, 8'hFF);
    $display("test registers done");
  endtask : test_regs
  task automatic test_read_ack;
    wr(`OFF_EVT_MASK, 8'h01);
    step(8'hA5, 8'h08);
    check8("irq raised", 8'h01, {7'h00, irq});
    wr(`OFF_EVT_STATUS, 8'h07);
    wr(`OFF_EVT_MASK, 8'h00);
    repeat (3) @(posedge clk);
    check8("irq cleared", 8'h00, {7'h00, irq});
    wr(`OFF_DATA, {ADDR, 1'b1});
    step(8'hC5, 8'h40);
    repeat (20) @(posedge clk);
    check8("clock held", 8'h01, {7'h00, scl_oe});
    expect_reg("masked event", `OFF_EVT_STATUS, 8'h01);
    check8("irq masked", 8'h00, {7'h00, irq});
    step(8'hC5, 8'h50);
    expect_reg("byte one", `OFF_DATA, SEED);
    step(8'h85, 8'h58);
    expect_reg("byte two", `OFF_DATA, SEED + 8'h01);
    wr(`OFF_EVT_STATUS, 8'h07);
    stop_seq();
    $display("test read with ack done");
  endtask : test_read_ack
  // Slow slave stretches every bit
  task automatic test_nack_restart;
    logic [7:0] s;
    stretch <= 4'h6;
    step(8'hA5, 8'h08);
    wr(`OFF_DATA, {ADDR ^ 7'h01, 1'b1});
    step(8'hC5, 8'h48);
    s = stops;
    step(8'hB5, 8'h08);
    check8("stop then start", s + 8'h01, stops);
    wr(`OFF_DATA, {ADDR, 1'b0});
    step(8'hC5, 8'h20);
    step(8'hA5, 8'h10);
    wr(`OFF_DATA, {ADDR, 1'b1});
    step(8'h85, 8'h40);
    step(8'h85, 8'h58);
    expect_reg("nack byte", `OFF_DATA, SEED);
    step(8'hA5, 8'h10);
    wr(`OFF_DATA, {ADDR, 1'b1});
    step(8'h85, 8'h40);
    step(8'h85, 8'h58);
    stop_seq();
    $display("test nack and restart done");
  endtask : test_nack_restart
  // Rival master pulls data low in the address
  task automatic test_arb_lost;
    stretch <= 4'h0;
    wr(`OFF_EVT_MASK, 8'h02);
    step(8'hA5, 8'h08);
    wr(`OFF_DATA, {ADDR, 1'b1});
    rival <= 1'b1;
    step(8'h85, 8'h38);
    check8("lines freed", 8'h00, {6'h00, scl_oe, sda_oe});
    check8("arb irq", 8'h01, {7'h00, irq});
    wr(`OFF_CONTROL, 8'hA5);
    rival <= 1'b0;
    poll("irq flag", 8'h80, 8'h80);
    expect_reg("start when free", `OFF_STATUS, 8'h08);
    wr(`OFF_DATA, {ADDR, 1'b1});
    step(8'h85, 8'h40);
    step(8'h85, 8'h58);
    wr(`OFF_EVT_STATUS, 8'h07);
    wr(`OFF_EVT_MASK, 8'h00);
    stop_seq();
    $display("test arbitration done");
  endtask : test_arb_lost

  task automatic finish_test;
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // ====
  // Clock, sequence and watchdog
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_regs();
    test_read_ack();
    test_nack_restart();
    test_arb_lost();
    finish_test();
  end
  // Far beyond the run length
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : testbench

// [testbench/two_wire_master_receiver_sva.sv]
// Port assertions for the master receiver
`timescale 1ns/100ps
`include "two_wire_defines.svh"

module two_wire_master_receiver_sva #(
  parameter int unsigned HALF_BIT = 4
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset
  input two_wire_pkg::reg_req_type req, // Register request
  input wire logic [7:0] rdata, // Read data
  input wire logic irq, // Level interrupt
  input wire logic scl_i, // Clock line level
  input wire logic scl_oe, // Clock pull-down
  input wire logic sda_i, // Data line level
  input wire logic sda_oe // Data pull-down
);
  import two_wire_pkg::*;
  localparam int HB = HALF_BIT;
  localparam int HB2 = 2 * HALF_BIT + 2;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  logic [2:0] mask_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ====
  // Phase length counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 16'h0000;
      high_cnt <= 16'h0000;
    end else begin
      low_cnt <= scl_oe ? low_cnt + 16'h0001 : 16'h0000;
      high_cnt <= scl_oe ? 16'h0000 : high_cnt + 16'h0001;
    end
  end
  // ====
  // Shadow of the event mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mask_q <= 3'b000;
    else if (req.wr && req.addr == `OFF_EVT_MASK) mask_q <= req.wdata[2:0];
  end
  // ====
  // Assertions
  a_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("stray read data");
  a_status_low_zero: assert property (req.rd && req.addr == `OFF_STATUS
    |=> rdata[2:0] == 3'b000) else $error("status low bits not zero");
  a_status_code_legal: assert property (req.rd && req.addr == `OFF_STATUS
    |=> rdata inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h38, 8'h40, 8'h48,
    8'h50, 8'h58, 8'hF8}) else $error("bad status code");
  a_start_free_bus: assert property ($rose(sda_oe) && !scl_oe
    |-> scl_i && $past(sda_i)) else $error("start on a busy bus");
  a_start_then_clock: assert property ($rose(sda_oe) && !scl_oe
    |-> ##[1:HB2] scl_oe) else $error("no clock low after start");
  a_scl_low_min: assert property ($fell(scl_oe) |-> low_cnt >= HB)
    else $error("short clock low");
  a_scl_high_min: assert property ($rose(scl_oe) |-> high_cnt >= HB)
    else $error("short clock high");
  a_irq_masked_off: assert property (mask_q == 3'b000
    && $past(mask_q) == 3'b000 |-> !irq) else $error("irq with mask clear");
  a_evt_upper_zero: assert property (req.rd && req.addr == `OFF_EVT_STATUS
    |=> rdata[7:3] == 5'h00) else $error("event upper bits set");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_irq: cover property ($rose(irq));
  c_data_ack: cover property (req.rd && req.addr == `OFF_STATUS
    ##1 rdata == 8'h50);
endmodule : two_wire_master_receiver_sva

bind two_wire_master_receiver two_wire_master_receiver_sva #(
  .HALF_BIT(HALF_BIT)
) two_wire_master_receiver_sva_i (
  .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .irq(irq),
  .scl_i(scl_i), .scl_oe(scl_oe), .sda_i(sda_i), .sda_oe(sda_oe)
);
